/* src/ppmc_defs.svh */
// constants for the partition protection and mode controller
`ifndef PPMC_DEFS_SVH
`define PPMC_DEFS_SVH

// ****************************************
// widths
// ****************************************
`define PPMC_AW           13
`define PPMC_DW           16
`define PPMC_WB_AW        8

// ****************************************
// timing
// ****************************************
`define PPMC_CLK_NS       100
`define PPMC_SETUP_NS     100
`define PPMC_STROBE_NS    250
`define PPMC_HOLD_NS      100
`define PPMC_RST_PULSE_NS 1000
`define PPMC_BUSY_MAX_NS  1300000
`define PPMC_SETUP_CYC    ((`PPMC_SETUP_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)
`define PPMC_STROBE_CYC   ((`PPMC_STROBE_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)
`define PPMC_HOLD_CYC     ((`PPMC_HOLD_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)
`define PPMC_RST_CYC      ((`PPMC_RST_PULSE_NS + `PPMC_CLK_NS - 1) / `PPMC_CLK_NS)
`define PPMC_BUSY_CYC     (`PPMC_BUSY_MAX_NS / `PPMC_CLK_NS)

// ****************************************
// device addresses and sequence values
// ****************************************
`define PPMC_DEV_CTRL_ADDR 13'h1002
`define PPMC_DEV_CONF_ADDR 13'h1003
`define PPMC_DEV_WAKE_ADDR 13'h1FFF
`define PPMC_MODE_NORMAL_V 16'h0005
`define PPMC_MODE_PDOWN_V  16'h0002
`define PPMC_WAKE_READS    3'h4

// ****************************************
// software register map
// ****************************************
`define PPMC_REG_CTRL     8'h00
`define PPMC_REG_ADDR     8'h04
`define PPMC_REG_WDATA    8'h08
`define PPMC_REG_RDATA    8'h0C
`define PPMC_REG_STATUS   8'h10

// ctrl fields
`define PPMC_CTRL_GO      0
`define PPMC_CTRL_CMD_LO  1
`define PPMC_CTRL_CMD_HI  3
`define PPMC_CTRL_LOCK    4
`define PPMC_CTRL_UBE     5

// status fields
`define PPMC_ST_ACTIVE    0
`define PPMC_ST_DONE      1
`define PPMC_ST_REFUSED   2
`define PPMC_ST_TIMEOUT   3
`define PPMC_ST_MODE_LO   4
`define PPMC_ST_MODE_HI   5
`define PPMC_ST_BUSYPIN   6

// command codes
`define PPMC_CMD_READ     3'h0
`define PPMC_CMD_WRITE    3'h1
`define PPMC_CMD_NORMAL   3'h2
`define PPMC_CMD_PDOWN    3'h3
`define PPMC_CMD_WAKE     3'h4
`define PPMC_CMD_RESET    3'h5

// mode codes
`define PPMC_MODE_RESET   2'h0
`define PPMC_MODE_NORMAL  2'h1
`define PPMC_MODE_DPD     2'h2

`endif

/* src/ppmc_pkg.sv */
// types shared by the protection and mode controller
package ppmc_pkg;
  `include "ppmc_defs.svh"

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic                  we;
    logic [`PPMC_AW-1:0]   addr;
    logic [`PPMC_DW-1:0]   data;
  } ppmc_req_s;

  typedef struct packed {
    logic                  ce_n;
    logic                  we_n;
    logic                  oe_n;
    logic [`PPMC_AW-1:0]   addr;
    logic [`PPMC_DW-1:0]   dout;
    logic                  doe;
  } ppmc_pins_s;
endpackage

/* src/ppmc_cycle.sv */
// one asynchronous memory-style bus cycle towards the flash disk
`timescale 1ns/100ps
`include "ppmc_defs.svh"
module ppmc_cycle
  import ppmc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                start,
  input  wire ppmc_req_s           req,
  input  wire logic [`PPMC_DW-1:0] din,
  output ppmc_pins_s               pins,
  output logic [`PPMC_DW-1:0]      rdata,
  output logic                     done
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} ppmc_cyc_e;

  ppmc_cyc_e            st_reg, st_next;
  logic [3:0]           cnt_reg, cnt_next;
  ppmc_req_s            req_reg, req_next;
  ppmc_pins_s           pins_reg, pins_next;
  logic [`PPMC_DW-1:0]  rdata_reg, rdata_next;
  logic                 done_reg, done_next;

  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    req_next   = req_reg;
    pins_next  = pins_reg;
    rdata_next = rdata_reg;
    done_next  = 1'b0;
    unique case (st_reg)
      C_IDLE:
      begin
        // idle bus parked static so the device can shut its input buffers
        pins_next = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dout: '0, doe: 1'b0};
        if (start)
        begin
          req_next       = req;
          pins_next.ce_n = 1'b0;
          pins_next.addr = req.addr;
          pins_next.dout = req.data;
          pins_next.doe  = req.we;
          cnt_next       = 4'(`PPMC_SETUP_CYC);
          st_next        = C_SETUP;
        end
      end
      C_SETUP:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          // strobe only inside chip select, never alone
          pins_next.we_n = ~req_reg.we;
          pins_next.oe_n = req_reg.we;
          cnt_next       = 4'(`PPMC_STROBE_CYC);
          st_next        = C_STROBE;
        end
      end
      C_STROBE:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          if (!req_reg.we)
            rdata_next = din;
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
          cnt_next       = 4'(`PPMC_HOLD_CYC);
          st_next        = C_HOLD;
        end
      end
      C_HOLD:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          pins_next.ce_n = 1'b1;
          pins_next.doe  = 1'b0;
          done_next      = 1'b1;
          st_next        = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg    <= C_IDLE;
      cnt_reg   <= 4'h0;
      req_reg   <= '0;
      pins_reg  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dout: '0, doe: 1'b0};
      rdata_reg <= '0;
      done_reg  <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      req_reg   <= req_next;
      pins_reg  <= pins_next;
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
    end
  end

  assign pins  = pins_reg;
  assign rdata = rdata_reg;
  assign done  = done_reg;

endmodule

/* src/ppmc_ctrl.sv */
// host controller: wishbone registers driving the flash disk pins
//
// Behaviour
// - control then confirmation write enters normal; host does this before reads
// - power-down sequence then chip select negated enters deep power-down
// - four reads from 1FFF leave deep power-down; data undefined
// - host ensures device awake before boot fetch, via reset pulse and busy
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`include "ppmc_defs.svh"
module ppmc_ctrl
  import ppmc_pkg::*;
#(
  parameter int BUSY_WAIT_CYC = `PPMC_BUSY_CYC
)
(
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_B,
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  input  wire logic                   WB_WE_I,
  input  wire logic [`PPMC_WB_AW-1:0] WB_ADR_I,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic [31:0]            WB_DAT_I,
  output logic      [31:0]            WB_DAT_O,
  output logic                        WB_ACK_O,
  output logic                        DEV_CE_N,
  output logic                        DEV_WE_N,
  output logic                        DEV_OE_N,
  output logic      [`PPMC_AW-1:0]    DEV_ADDR,
  output logic      [`PPMC_DW-1:0]    DEV_DATA_O,
  output logic                        DEV_DATA_OE,
  input  wire logic [`PPMC_DW-1:0]    DEV_DATA_I,
  output logic                        DEV_UPPER_BYTE_EN_N,
  output logic                        DEV_RESET_INPUT_N,
  output logic                        DEV_LOCK_N,
  input  wire logic                   DEV_BUSY_N
);

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_CYCLE, S_RST_PULSE, S_RST_WAIT} ppmc_state_e;

  ppmc_state_e          st_reg, st_next;
  logic [2:0]           cmd_reg, cmd_next;
  logic [2:0]           step_reg, step_next;
  logic [15:0]          cnt_reg, cnt_next;
  logic [1:0]           mode_reg, mode_next;
  logic [`PPMC_AW-1:0]  addr_reg, addr_next;
  logic [`PPMC_DW-1:0]  wdata_reg, wdata_next;
  logic [`PPMC_DW-1:0]  rdata_reg, rdata_next;
  logic                 lock_reg, lock_next;
  logic                 ube_reg, ube_next;
  logic                 done_reg, done_next;
  logic                 refused_reg, refused_next;
  logic                 tmo_reg, tmo_next;
  logic                 rst_out_reg, rst_out_next;
  logic                 ack_reg, ack_next;
  logic [31:0]          dat_reg, dat_next;
  logic                 cyc_start;
  ppmc_req_s            cyc_req;
  ppmc_pins_s           pins;
  logic [`PPMC_DW-1:0]  cyc_rdata;
  logic                 cyc_done;
  logic                 wb_req;
  logic                 wb_wr;
  logic [2:0]           go_cmd;
  logic                 go;
  logic                 refuse;

  // ****************************************
  // sequence table
  // ****************************************
  function automatic ppmc_req_s step_req(input logic [2:0] cmd, input logic [2:0] step,
                                         input logic [`PPMC_AW-1:0] a,
                                         input logic [`PPMC_DW-1:0] d);
    ppmc_req_s r;
    r = '{we: 1'b0, addr: a, data: '0};
    unique case (cmd)
      `PPMC_CMD_WRITE:  r = '{we: 1'b1, addr: a, data: d};
      // control then confirmation, confirmation carries the complement
      `PPMC_CMD_NORMAL: r = '{we: 1'b1,
                              addr: (step == 3'h0) ? `PPMC_DEV_CTRL_ADDR : `PPMC_DEV_CONF_ADDR,
                              data: (step == 3'h0) ? `PPMC_MODE_NORMAL_V
                                                   : ~`PPMC_MODE_NORMAL_V};
      `PPMC_CMD_PDOWN:  r = '{we: 1'b1,
                              addr: (step == 3'h0) ? `PPMC_DEV_CTRL_ADDR : `PPMC_DEV_CONF_ADDR,
                              data: (step == 3'h0) ? `PPMC_MODE_PDOWN_V
                                                   : ~`PPMC_MODE_PDOWN_V};
      `PPMC_CMD_WAKE:   r = '{we: 1'b0, addr: `PPMC_DEV_WAKE_ADDR, data: '0};
      default:          r = '{we: 1'b0, addr: a, data: '0};
    endcase
    return r;
  endfunction

  function automatic logic [2:0] step_count(input logic [2:0] cmd);
    logic [2:0] n;
    n = 3'h1;
    if (cmd == `PPMC_CMD_WAKE)
      n = `PPMC_WAKE_READS;
    else if (cmd == `PPMC_CMD_NORMAL || cmd == `PPMC_CMD_PDOWN)
      n = 3'h2;
    return n;
  endfunction

  // ****************************************
  // wishbone decode
  // ****************************************
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg;
  assign wb_wr  = wb_req && WB_WE_I;
  assign go_cmd = WB_DAT_I[`PPMC_CTRL_CMD_HI:`PPMC_CTRL_CMD_LO];
  assign go     = wb_wr && (WB_ADR_I == `PPMC_REG_CTRL) && WB_SEL_I[0]
                  && WB_DAT_I[`PPMC_CTRL_GO] && (st_reg == S_IDLE);
  // reads need normal mode; deep power-down only accepts wake, normal or reset
  assign refuse = ((go_cmd == `PPMC_CMD_READ) && (mode_reg != `PPMC_MODE_NORMAL))
               || ((go_cmd == `PPMC_CMD_WRITE) && (mode_reg == `PPMC_MODE_DPD))
               || ((go_cmd == `PPMC_CMD_PDOWN) && (mode_reg != `PPMC_MODE_NORMAL))
               || ((go_cmd == `PPMC_CMD_WAKE) && (mode_reg != `PPMC_MODE_DPD))
               || (go_cmd > `PPMC_CMD_RESET);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_next      = st_reg;
    cmd_next     = cmd_reg;
    step_next    = step_reg;
    cnt_next     = cnt_reg;
    mode_next    = mode_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    rdata_next   = rdata_reg;
    lock_next    = lock_reg;
    ube_next     = ube_reg;
    done_next    = done_reg;
    refused_next = refused_reg;
    tmo_next     = tmo_reg;
    rst_out_next = rst_out_reg;
    ack_next     = wb_req;
    dat_next     = 32'h0000_0000;
    cyc_start    = 1'b0;
    cyc_req      = step_req(cmd_reg, step_reg, addr_reg, wdata_reg);

    if (wb_req && !WB_WE_I)
    begin
      unique case (WB_ADR_I)
        `PPMC_REG_CTRL:   dat_next = {26'h0, ube_reg, lock_reg, cmd_reg, 1'b0};
        `PPMC_REG_ADDR:   dat_next = {19'h0, addr_reg};
        `PPMC_REG_WDATA:  dat_next = {16'h0, wdata_reg};
        `PPMC_REG_RDATA:  dat_next = {16'h0, rdata_reg};
        `PPMC_REG_STATUS: dat_next = {25'h0, ~DEV_BUSY_N, mode_reg, tmo_reg, refused_reg,
                                      done_reg, (st_reg != S_IDLE)};
        default:          dat_next = 32'h0000_0000;
      endcase
    end

    if (wb_wr)
    begin
      unique case (WB_ADR_I)
        `PPMC_REG_CTRL:
        begin
          if (WB_SEL_I[0])
          begin
            // lock pin for sessions; the sticky bit itself is a device write
            lock_next = WB_DAT_I[`PPMC_CTRL_LOCK];
            ube_next  = WB_DAT_I[`PPMC_CTRL_UBE];
          end
        end
        `PPMC_REG_ADDR:
        begin
          if (WB_SEL_I[0])
            addr_next[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1])
            addr_next[`PPMC_AW-1:8] = WB_DAT_I[`PPMC_AW-1:8];
        end
        `PPMC_REG_WDATA:
        begin
          if (WB_SEL_I[0])
            wdata_next[7:0] = WB_DAT_I[7:0];
          if (WB_SEL_I[1])
            wdata_next[15:8] = WB_DAT_I[15:8];
        end
        `PPMC_REG_STATUS:
        begin
          if (WB_SEL_I[0] && WB_DAT_I[`PPMC_ST_DONE])
            done_next = 1'b0;
          if (WB_SEL_I[0] && WB_DAT_I[`PPMC_ST_REFUSED])
            refused_next = 1'b0;
          if (WB_SEL_I[0] && WB_DAT_I[`PPMC_ST_TIMEOUT])
            tmo_next = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    unique case (st_reg)
      S_IDLE:
      begin
        if (go && refuse)
          refused_next = 1'b1;
        else if (go)
        begin
          cmd_next  = go_cmd;
          step_next = 3'h0;
          if (go_cmd == `PPMC_CMD_RESET)
          begin
            // pulse reset so boot fetch never meets a sleeping device
            rst_out_next = 1'b0;
            cnt_next     = 16'(`PPMC_RST_CYC);
            st_next      = S_RST_PULSE;
          end
          else
            st_next = S_CYCLE;
        end
      end
      S_CYCLE:
      begin
        cyc_start = (cnt_reg == 16'h0000);
        cnt_next  = 16'h0001;
        if (cyc_done)
        begin
          cnt_next  = 16'h0000;
          step_next = step_reg + 3'h1;
          if (cmd_reg == `PPMC_CMD_READ)
            rdata_next = cyc_rdata;
          if (step_reg + 3'h1 == step_count(cmd_reg))
          begin
            st_next   = S_IDLE;
            done_next = 1'b1;
            if (cmd_reg == `PPMC_CMD_NORMAL || cmd_reg == `PPMC_CMD_WAKE)
              mode_next = `PPMC_MODE_NORMAL;
            else if (cmd_reg == `PPMC_CMD_PDOWN)
              mode_next = `PPMC_MODE_DPD;
          end
        end
      end
      S_RST_PULSE:
      begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0001)
        begin
          rst_out_next = 1'b1;
          mode_next    = `PPMC_MODE_RESET;
          cnt_next     = 16'(BUSY_WAIT_CYC);
          st_next      = S_RST_WAIT;
        end
      end
      S_RST_WAIT:
      begin
        // busy wait bounded by the longest load time
        cnt_next = cnt_reg - 16'h0001;
        if (DEV_BUSY_N)
        begin
          st_next   = S_IDLE;
          done_next = 1'b1;
        end
        else if (cnt_reg == 16'h0000)
        begin
          st_next   = S_IDLE;
          done_next = 1'b1;
          tmo_next  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_reg      <= S_IDLE;
      cmd_reg     <= `PPMC_CMD_READ;
      step_reg    <= 3'h0;
      cnt_reg     <= 16'h0000;
      mode_reg    <= `PPMC_MODE_RESET;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      rdata_reg   <= '0;
      lock_reg    <= 1'b0;
      ube_reg     <= 1'b0;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      tmo_reg     <= 1'b0;
      rst_out_reg <= 1'b1;
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h0000_0000;
    end
    else
    begin
      st_reg      <= st_next;
      cmd_reg     <= cmd_next;
      step_reg    <= step_next;
      cnt_reg     <= cnt_next;
      mode_reg    <= mode_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      rdata_reg   <= rdata_next;
      lock_reg    <= lock_next;
      ube_reg     <= ube_next;
      done_reg    <= done_next;
      refused_reg <= refused_next;
      tmo_reg     <= tmo_next;
      rst_out_reg <= rst_out_next;
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
    end
  end

  // ****************************************
  // device bus cycle engine
  // ****************************************
  ppmc_cycle u_cycle (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .start (cyc_start),
    .req   (cyc_req),
    .din   (DEV_DATA_I),
    .pins  (pins),
    .rdata (cyc_rdata),
    .done  (cyc_done)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign WB_ACK_O            = ack_reg;
  assign WB_DAT_O            = dat_reg;
  assign DEV_CE_N            = pins.ce_n;
  assign DEV_WE_N            = pins.we_n;
  assign DEV_OE_N            = pins.oe_n;
  assign DEV_ADDR            = pins.addr;
  assign DEV_DATA_O          = pins.dout;
  assign DEV_DATA_OE         = pins.doe;
  // held high in power-down to keep this input static; DEV_LOCK_N still follows the lock bit
  assign DEV_UPPER_BYTE_EN_N = ~ube_reg | (mode_reg == `PPMC_MODE_DPD);
  // reset never held long: a held reset in normal mode would sleep the part
  assign DEV_RESET_INPUT_N   = rst_out_reg;
  assign DEV_LOCK_N          = ~lock_reg;

endmodule

/* verif/ppmc_ctrl_asserts.sv */
// port-level checks for the protection and mode controller
`timescale 1ns/100ps
`include "ppmc_defs.svh"
module ppmc_ctrl_asserts
#(
  parameter int BUSY_WAIT_CYC = 50
)
(
  input wire logic                CORE_CLK,
  input wire logic                RST_B,
  input wire logic                WB_CYC_I,
  input wire logic                WB_STB_I,
  input wire logic                WB_ACK_O,
  input wire logic                DEV_CE_N,
  input wire logic                DEV_WE_N,
  input wire logic                DEV_OE_N,
  input wire logic [`PPMC_AW-1:0] DEV_ADDR,
  input wire logic                DEV_DATA_OE,
  input wire logic                DEV_RESET_INPUT_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // ****************************************
  // register bus
  // ****************************************
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered next cycle");
  // ****************************************
  // device cycles
  // ****************************************
  a_write_in_select: assert property (!DEV_WE_N |-> !DEV_CE_N && DEV_OE_N && DEV_DATA_OE)
    else $error("write strobe outside a driven select");
  a_read_in_select: assert property (!DEV_OE_N |-> !DEV_CE_N && !DEV_DATA_OE)
    else $error("read strobe outside select or with data driven");
  a_write_width: assert property ($fell(DEV_WE_N) |-> !DEV_WE_N[*3] ##1 DEV_WE_N)
    else $error("write strobe width wrong");
  a_read_width: assert property ($fell(DEV_OE_N) |-> !DEV_OE_N[*3] ##1 DEV_OE_N)
    else $error("read strobe width wrong");
  a_select_setup: assert property ($fell(DEV_CE_N) |->
    DEV_WE_N && DEV_OE_N ##1 (!DEV_WE_N || !DEV_OE_N))
    else $error("no setup cycle before strobe");
  a_select_hold: assert property ($rose(DEV_WE_N) || $rose(DEV_OE_N) |->
    !DEV_CE_N ##1 DEV_CE_N)
    else $error("select hold cycle missing");
  a_addr_steady: assert property (!DEV_WE_N || !DEV_OE_N |-> $stable(DEV_ADDR))
    else $error("address moved under a strobe");
  a_reset_pulse: assert property ($fell(DEV_RESET_INPUT_N) |->
    !DEV_RESET_INPUT_N[*8] ##1 !DEV_RESET_INPUT_N[*2] ##1 DEV_RESET_INPUT_N)
    else $error("device reset pulse length wrong");
  a_quiet_in_reset: assert property (!DEV_RESET_INPUT_N |-> DEV_CE_N)
    else $error("device selected during its reset");
  c_write: cover property ($fell(DEV_WE_N));
  c_read: cover property ($fell(DEV_OE_N));
  c_reset: cover property ($fell(DEV_RESET_INPUT_N));
  c_ack: cover property (WB_ACK_O);
endmodule

bind ppmc_ctrl ppmc_ctrl_asserts #(.BUSY_WAIT_CYC(BUSY_WAIT_CYC)) u_ppmc_ctrl_asserts (.*);

/* verif/ppmc_dev_model.sv */
// behavioural flash disk: modes, control sequence and a small register file
`timescale 1ns/100ps
`include "ppmc_defs.svh"
module ppmc_dev_model
#(
  parameter int BUSY_NS = 2000
)
(
  input  wire logic                ce_n,
  input  wire logic                we_n,
  input  wire logic                oe_n,
  input  wire logic [`PPMC_AW-1:0] addr,
  input  wire logic [`PPMC_DW-1:0] din,
  input  wire logic                rst_in_n,
  input  wire logic                stall,
  output logic      [`PPMC_DW-1:0] dout,
  output logic                     busy_n
);
  logic [1:0]  mode_reg = `PPMC_MODE_RESET;
  logic [15:0] ctrl_reg = 16'h0000;
  logic        pd_pend  = 1'b0;
  logic [2:0]  wake_cnt = 3'h0;
  logic [15:0] mem_reg [16];
  initial busy_n = 1'b1;
  initial dout = 16'h5A5A;
  // ****************************************
  // reset input and loading
  // ****************************************
  always @(negedge rst_in_n)
  begin
    mode_reg = `PPMC_MODE_RESET;
    pd_pend  = 1'b0;
    busy_n   = 1'b0;
  end
  // stall stretches loading past the host's limit on purpose
  always @(posedge rst_in_n)
  begin
    #(BUSY_NS);
    wait (!stall);
    busy_n = 1'b1;
  end
  // ****************************************
  // cycles
  // ****************************************
  always @(posedge we_n)
  begin
    if (!ce_n && mode_reg != `PPMC_MODE_DPD)
    begin
      if (addr == `PPMC_DEV_CTRL_ADDR)
        ctrl_reg = din;
      else if (addr == `PPMC_DEV_CONF_ADDR && din == ~ctrl_reg)
      begin
        pd_pend = ctrl_reg == `PPMC_MODE_PDOWN_V && mode_reg == `PPMC_MODE_NORMAL;
        if (ctrl_reg == `PPMC_MODE_NORMAL_V)
          mode_reg = `PPMC_MODE_NORMAL;
      end
      else if (mode_reg == `PPMC_MODE_NORMAL)
        mem_reg[addr[3:0]] = din;
    end
  end
  always @(posedge ce_n)
    if (pd_pend)
    begin
      mode_reg = `PPMC_MODE_DPD;
      pd_pend  = 1'b0;
    end
  always @(negedge oe_n)
  begin
    if (!ce_n && mode_reg == `PPMC_MODE_DPD)
    begin
      dout     = ~dout;
      wake_cnt = (addr == `PPMC_DEV_WAKE_ADDR) ? wake_cnt + 3'h1 : 3'h0;
      if (wake_cnt == `PPMC_WAKE_READS)
      begin
        mode_reg = `PPMC_MODE_NORMAL;
        wake_cnt = 3'h0;
      end
    end
    else if (!ce_n)
      dout = (mode_reg == `PPMC_MODE_NORMAL) ? mem_reg[addr[3:0]] : 16'h0000;
  end
  // released bus never repeats the last value
  always @(posedge oe_n)
    dout = ~dout;
endmodule

/* verif/ppmc_ctrl_tb.sv */
// self-checking bench for the protection and mode controller
`timescale 1ns/100ps
`include "ppmc_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ppmc_ctrl_tb;
  typedef struct packed {
    logic [2:0]  cmd;
    logic [12:0] adr;
    logic [15:0] wd;
    logic        rf;
    logic [1:0]  md;
  } ppmc_row_s;
  logic        CORE_CLK = 1'b0, RST_B = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [3:0]  WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, st;
  logic [12:0] DEV_ADDR;
  logic [15:0] DEV_DATA_O, DEV_DATA_I;
  logic        WB_ACK_O, DEV_CE_N, DEV_WE_N, DEV_OE_N, DEV_DATA_OE, DEV_UPPER_BYTE_EN_N;
  logic        DEV_RESET_INPUT_N, DEV_LOCK_N, DEV_BUSY_N, stall = 1'b0;
  int          err_total = 0, tests_run = 0, cyc_cnt = 0;
  // reset, illegal codes, every command, power-down round trip
  ppmc_row_s   rows [16] = '{'{3'h0,13'h5,16'h0,1'b1,2'h0}, '{3'h4,13'h0,16'h0,1'b1,2'h0},
    '{3'h3,13'h0,16'h0,1'b1,2'h0}, '{3'h6,13'h0,16'h0,1'b1,2'h0}, '{3'h7,13'h0,16'h0,1'b1,2'h0},
    '{3'h2,13'h0,16'h0,1'b0,2'h1}, '{3'h1,13'h5,16'hA5A5,1'b0,2'h1}, '{3'h0,13'h5,16'h0,1'b0,2'h1},
    '{3'h4,13'h0,16'h0,1'b1,2'h1}, '{3'h3,13'h0,16'h0,1'b0,2'h2}, '{3'h1,13'h5,16'h1234,1'b1,2'h2},
    '{3'h0,13'h5,16'h0,1'b1,2'h2}, '{3'h4,13'h0,16'h0,1'b0,2'h1}, '{3'h0,13'h5,16'h0,1'b0,2'h1},
    '{3'h5,13'h0,16'h0,1'b0,2'h0}, '{3'h0,13'h5,16'h0,1'b1,2'h0}};
  ppmc_ctrl #(.BUSY_WAIT_CYC(50)) u_ppmc_ctrl (.*);
  ppmc_dev_model u_ppmc_dev_model (.ce_n(DEV_CE_N), .we_n(DEV_WE_N), .oe_n(DEV_OE_N),
    .addr(DEV_ADDR), .din(DEV_DATA_O), .rst_in_n(DEV_RESET_INPUT_N), .stall(stall),
    .dout(DEV_DATA_I), .busy_n(DEV_BUSY_N));
  always #50 CORE_CLK = ~CORE_CLK;
  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // entered just after a rising edge; leaves one idle cycle behind
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do @(posedge CORE_CLK); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task automatic run(input logic [2:0] c, output logic [31:0] q);
    int n;
    n = 0;
    wb(1'b1, `PPMC_REG_STATUS, 32'hE, q);
    wb(1'b1, `PPMC_REG_CTRL, {26'h0, 2'h2, c, 1'b1}, q);
    do begin wb(1'b0, `PPMC_REG_STATUS, 32'h0, q); n++; end
    while (q[`PPMC_ST_ACTIVE] !== 1'b0 && n < 200);
    `CHK("active", 1'b0, q[`PPMC_ST_ACTIVE])
  endtask
  // ****************************************
  // sequence
  // ****************************************
  always @(posedge CORE_CLK)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    @(posedge CORE_CLK);
    `CHK("rst pin", 1'b1, DEV_RESET_INPUT_N)
    foreach (rows[i])
    begin
      wb(1'b1, `PPMC_REG_ADDR, {19'h0, rows[i].adr}, st);
      wb(1'b1, `PPMC_REG_WDATA, {16'h0, rows[i].wd}, st);
      run(rows[i].cmd, st);
      `CHK("refused", rows[i].rf, st[`PPMC_ST_REFUSED])
      `CHK("mode", rows[i].md, st[`PPMC_ST_MODE_HI:`PPMC_ST_MODE_LO])
      `CHK("dev mode", rows[i].md, u_ppmc_dev_model.mode_reg)
      `CHK("done", !rows[i].rf, st[`PPMC_ST_DONE])
      `CHK("ube dpd", rows[i].md == 2'h2, DEV_UPPER_BYTE_EN_N)
      if (rows[i].cmd == 3'h0 && !rows[i].rf)
      begin
        wb(1'b0, `PPMC_REG_RDATA, 32'h0, st);
        `CHK("rdata", 32'hA5A5, st)
      end
    end
    wb(1'b1, 8'h14, 32'hFFFFFFFF, st);
    wb(1'b0, 8'h14, 32'h0, st);
    `CHK("unmapped", 32'h0, st)
    wb(1'b1, `PPMC_REG_CTRL, 32'h30, st);
    wb(1'b0, `PPMC_REG_CTRL, 32'h0, st);
    `CHK("ctrl", 32'h3A, st)
    `CHK("lock pin", 1'b0, DEV_LOCK_N)
    `CHK("ube pin", 1'b0, DEV_UPPER_BYTE_EN_N)
    // loading that never ends must give up, not hang
    stall <= 1'b1;
    run(3'h5, st);
    `CHK("timeout", 1'b1, st[`PPMC_ST_TIMEOUT])
    `CHK("busy bit", 1'b1, st[`PPMC_ST_BUSYPIN])
    stall <= 1'b0;
    repeat (40) @(posedge CORE_CLK);
    wb(1'b1, `PPMC_REG_CTRL, {28'h0, 3'h2, 1'b1}, st);
    repeat (3) @(posedge CORE_CLK);
    RST_B <= 1'b0;
    @(posedge CORE_CLK);
    `CHK("ce idle", 1'b1, DEV_CE_N)
    `CHK("ack idle", 1'b0, WB_ACK_O)
    RST_B <= 1'b1;
    @(posedge CORE_CLK);
    wb(1'b0, `PPMC_REG_STATUS, 32'h0, st);
    `CHK("mode rst", 2'h0, st[`PPMC_ST_MODE_HI:`PPMC_ST_MODE_LO])
    print_verdict();
  end
endmodule
